//--- hw/status_ind_pkg.sv
// Shared constants for the drive status indicator logic.
// Assumes a single 50 MHz clock domain and synchronous inputs.
package status_ind_pkg;

  // Clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 20;
  // Half period of the shared flash toggle, in milliseconds.
  localparam int unsigned FLASH_HALF_MS = 250;
  // Cycles in one flash half period, rounded down.
  localparam int unsigned FLASH_HALF_CYC = (FLASH_HALF_MS * 1000000) / CLK_PERIOD_NS;

  // Number of function indicators in the select cycle.
  localparam int unsigned NUM_FUNC = 8;
  // Width of the function index.
  localparam int unsigned FUNC_W = 3;
  // Function index selected after reset.
  localparam logic [FUNC_W-1:0] FUNC_RST = 3'h0;

  // Parameter access level that still allows running in program mode.
  localparam logic [3:0] ACCESS_RUN_IN_PRGM = 4'h5;

  // Indicator display pattern.
  typedef enum logic [1:0] {
    LAMP_OFF,
    LAMP_ON,
    LAMP_FLASH
  } lamp_t;

  // Ranked drive condition, highest rank first; the last three listed rank in reverse order.
  typedef enum logic [3:0] {
    COND_POWER_DOWN,
    COND_FAULT,
    COND_ESTOP_ALARM,
    COND_ESTOP_FAULT,
    COND_ALARM_STOP,
    COND_ALARM_RUN,
    COND_STOP_BB,
    COND_RUNNING,
    COND_DECEL
  } cond_t;

  // Operator panel mode.
  typedef enum logic {
    MODE_DRIVE,
    MODE_PROGRAM
  } panel_mode_t;

endpackage

//--- hw/rise_detect.sv
// Rising edge detector producing a one-cycle pulse.
// Assumes the input is already synchronous to clk_i.
module rise_detect (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Level in, pulse out.
  input  wire logic level_i,
  output logic      pulse_o
);

  // Previous sample of the level.
  logic level_q;

  // Keep the last sample so a press counts once.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_i;
    end
  end

  // Pulse only on the low-to-high change.
  assign pulse_o = level_i & ~level_q;

endmodule

//--- hw/drive_status_indicator_logic.sv
// Status indicator, fault reset and panel mode logic for a motor drive.
// Assumes keys and terminal inputs are clean levels synchronous to clk_i.
// What this block does
// - Indicators follow the highest-ranked active condition.
// - Power down or not ready: all dark.
// - Fault ranks second; alarm lamp lit.
// - Run key lamp mirrors front run lamp.
// - Panel stop under terminal control or terminal alarm: emergency stop third.
// - Terminal emergency-stop fault ranks fourth.
// - Halted after emergency stop shows alarm/fault pattern.
// - Alarm stopped fifth, alarm running sixth.
// - Deceleration seventh, running eighth.
// - Running reported even below minimum frequency.
// - Stop and baseblock rank ninth.
// - Fault clears by reset or stop when idle.
// - Fault reset ignored while run asserted.
// - Display key steps function indicator cyclically.
// - Stop after parameter entry forces program mode.
// - Access level five allows running in program.
module drive_status_indicator_logic
  import status_ind_pkg::*;
#(
  parameter int unsigned FLASH_HALF = FLASH_HALF_CYC  // Cycles per flash half period.
) (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // Drive status inputs.
  input  wire logic              drive_ready_i,
  input  wire logic              fault_event_i,
  input  wire logic              alarm_i,
  input  wire logic              ext_baseblock_i,
  input  wire logic              output_active_i,
  input  wire logic              decel_i,
  // Control terminal inputs.
  input  wire logic              terminal_ctrl_i,
  input  wire logic              run_cmd_i,
  input  wire logic              fault_reset_i,
  input  wire logic              estop_alarm_i,
  input  wire logic              estop_fault_i,
  // Panel keys and settings.
  input  wire logic              stop_key_i,
  input  wire logic              display_select_key_i,
  input  wire logic              param_mode_i,
  input  wire logic [3:0]        param_access_level_i,
  // Indicators.
  output logic                   run_key_lamp_o,
  output logic                   run_lamp_o,
  output logic                   alarm_lamp_o,
  output logic [FUNC_W-1:0]      func_sel_o,
  output logic                   program_mode_o,
  output logic                   run_enable_o,
  output logic                   fault_latched_o
);

  // Flash counter width.
  localparam int unsigned CNT_W = $clog2(FLASH_HALF + 1);

  // Shared flash timer and phase.
  logic [CNT_W-1:0] flash_cnt_q;
  logic             flash_q;
  // Latched fault and emergency stop flags.
  logic             fault_q;
  logic             estop_alarm_q;
  logic             estop_fault_q;
  logic             estop_req;
  // Panel state.
  logic [FUNC_W-1:0] func_q;
  panel_mode_t       mode_q;
  logic              param_seen_q;
  // Key pulses.
  logic              dsel_pulse;
  logic              stop_pulse;
  // Condition and patterns.
  cond_t             cond;
  lamp_t             run_pat;
  lamp_t             alm_pat;
  logic              running;
  logic              clear_ok;
  logic              run_ok;

  // One press of the display key gives one step.
  rise_detect u_dsel (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .level_i (display_select_key_i),
    .pulse_o (dsel_pulse)
  );

  // One press of the stop key gives one clear attempt.
  rise_detect u_stop (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .level_i (stop_key_i),
    .pulse_o (stop_pulse)
  );

  // Free-running flash timer shared by all lamps.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flash_cnt_q <= '0;
      flash_q     <= 1'b0;
    end else if (flash_cnt_q == CNT_W'(FLASH_HALF - 1)) begin
      flash_cnt_q <= '0;
      flash_q     <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 1'b1;
    end
  end

  // A fault may be cleared only with the run signal off.
  assign clear_ok = ~run_cmd_i & (fault_reset_i | stop_pulse);
  // Panel stop under terminal control is an emergency stop.
  assign estop_req = stop_pulse & terminal_ctrl_i;

  // Fault latch; a new fault wins over a clear in the same cycle.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_q <= 1'b0;
    end else if (fault_event_i) begin
      fault_q <= 1'b1;
    end else if (clear_ok) begin
      fault_q <= 1'b0;
    end
  end

  // Emergency stop alarm latch, held until the drive restarts.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      estop_alarm_q <= 1'b0;
    end else if (estop_req || estop_alarm_i) begin
      estop_alarm_q <= 1'b1;
    end else if (run_cmd_i && !output_active_i && !decel_i) begin
      estop_alarm_q <= 1'b0;
    end
  end

  // Emergency stop fault latch, cleared like a fault.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      estop_fault_q <= 1'b0;
    end else if (estop_fault_i) begin
      estop_fault_q <= 1'b1;
    end else if (clear_ok) begin
      estop_fault_q <= 1'b0;
    end
  end

  // The drive counts as running whenever output is active and not decelerating, at any frequency.
  assign running = output_active_i & ~decel_i;

  // Priority selection of the single governing condition.
  always_comb begin
    if (!drive_ready_i) begin
      cond = COND_POWER_DOWN;
    end else if (fault_q) begin
      cond = COND_FAULT;
    end else if (estop_alarm_q) begin
      cond = COND_ESTOP_ALARM;
    end else if (estop_fault_q) begin
      cond = COND_ESTOP_FAULT;
    end else if (alarm_i && !running && !run_cmd_i) begin
      cond = COND_ALARM_STOP;
    end else if (alarm_i || (run_cmd_i && ext_baseblock_i)) begin
      cond = COND_ALARM_RUN;
    end else if (decel_i) begin
      cond = COND_DECEL;
    end else if (running) begin
      cond = COND_RUNNING;
    end else begin
      cond = COND_STOP_BB;
    end
  end

  // Lamp patterns for each condition.
  always_comb begin
    run_pat = LAMP_OFF;
    alm_pat = LAMP_OFF;
    case (cond)
      COND_POWER_DOWN: begin
        run_pat = LAMP_OFF;
        alm_pat = LAMP_OFF;
      end
      COND_FAULT: begin
        run_pat = LAMP_OFF;
        alm_pat = LAMP_ON;
      end
      COND_ESTOP_ALARM: begin
        // Show the stopped-alarm pattern, whether running down or halted.
        run_pat = LAMP_FLASH;
        alm_pat = LAMP_FLASH;
      end
      COND_ESTOP_FAULT: begin
        // Running down flashes run; once halted, the fault pattern.
        run_pat = (output_active_i) ? LAMP_FLASH : LAMP_OFF;
        alm_pat = LAMP_ON;
      end
      COND_ALARM_STOP: begin
        run_pat = LAMP_FLASH;
        alm_pat = LAMP_FLASH;
      end
      COND_ALARM_RUN: begin
        run_pat = LAMP_ON;
        alm_pat = LAMP_FLASH;
      end
      COND_STOP_BB: begin
        run_pat = LAMP_FLASH;
        alm_pat = LAMP_OFF;
      end
      COND_RUNNING: begin
        run_pat = LAMP_ON;
        alm_pat = LAMP_OFF;
      end
      COND_DECEL: begin
        run_pat = LAMP_FLASH;
        alm_pat = LAMP_OFF;
      end
      default: begin
        run_pat = LAMP_OFF;
        alm_pat = LAMP_OFF;
      end
    endcase
  end

  // Drive the lamps from flip-flops; both run lamps share one value.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_lamp_o     <= 1'b0;
      run_key_lamp_o <= 1'b0;
      alarm_lamp_o   <= 1'b0;
    end else begin
      run_lamp_o     <= (run_pat == LAMP_ON) | ((run_pat == LAMP_FLASH) & flash_q);
      run_key_lamp_o <= (run_pat == LAMP_ON) | ((run_pat == LAMP_FLASH) & flash_q);
      alarm_lamp_o   <= (alm_pat == LAMP_ON) | ((alm_pat == LAMP_FLASH) & flash_q);
    end
  end

  // Step the function indicator on each display key press.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      func_q <= FUNC_RST;
    end else if (dsel_pulse) begin
      if (func_q == FUNC_W'(NUM_FUNC - 1)) begin
        func_q <= FUNC_RST;
      end else begin
        func_q <= func_q + 1'b1;
      end
    end
  end

  // Remember a parameter mode entered while running; fall back on stop.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      param_seen_q <= 1'b0;
      mode_q       <= MODE_DRIVE;
    end else if (param_mode_i && output_active_i) begin
      param_seen_q <= 1'b1;
    end else if (param_seen_q && !output_active_i) begin
      param_seen_q <= 1'b0;
      mode_q       <= MODE_PROGRAM;
    end else if (!param_mode_i) begin
      mode_q       <= MODE_DRIVE;
    end
  end

  // Run is refused in program mode unless access level allows it.
  assign run_ok = (mode_q == MODE_DRIVE) | (param_access_level_i == ACCESS_RUN_IN_PRGM);

  // Register the remaining outputs.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      func_sel_o      <= FUNC_RST;
      program_mode_o  <= 1'b0;
      run_enable_o    <= 1'b0;
      fault_latched_o <= 1'b0;
    end else begin
      func_sel_o      <= func_q;
      program_mode_o  <= (mode_q == MODE_PROGRAM);
      run_enable_o    <= run_ok & drive_ready_i & ~fault_q;
      fault_latched_o <= fault_q;
    end
  end

  // Both run lamps always agree.
  chk_run_lamps_same: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    run_lamp_o == run_key_lamp_o) else $error("run lamps differ");

  // Not ready drives every lamp dark next cycle.
  chk_power_down_dark: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !drive_ready_i |=> !run_lamp_o && !alarm_lamp_o) else $error("lamps lit while not ready");

  // A latched fault lights the alarm lamp steadily.
  chk_fault_alarm_on: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    drive_ready_i && fault_q |=> alarm_lamp_o) else $error("alarm dark on fault");

  // Fault reset with run asserted leaves the fault.
  chk_reset_blocked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    fault_q && run_cmd_i |=> fault_q) else $error("fault cleared while running");

  // Fault reset with run off clears an idle fault.
  chk_reset_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    fault_q && fault_reset_i && !run_cmd_i && !fault_event_i |=> !fault_q)
    else $error("fault not cleared");

  // Display key steps the selection by one.
  chk_func_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    dsel_pulse && func_q != FUNC_W'(NUM_FUNC - 1) |=> func_q == $past(func_q) + 1'b1)
    else $error("function select did not step");

  // Stop after parameter entry forces program mode.
  chk_prgm_fallback: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    param_seen_q && !output_active_i && !(param_mode_i && output_active_i)
    |=> mode_q == MODE_PROGRAM) else $error("no program fallback");

  // Access level five keeps run allowed in program mode.
  // The edge of reset release is skipped, since the output flop is still held there.
  chk_access_run: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $past(rst_b_i) && param_access_level_i == ACCESS_RUN_IN_PRGM && drive_ready_i && !fault_q
    |=> run_enable_o)
    else $error("run refused at access level five");

  // Running without faults or alarms for two cycles lights the run lamp on the next cycle.
  chk_running_lamp: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cond == COND_RUNNING ##1 cond == COND_RUNNING |=> run_lamp_o) else $error("run lamp dark");

  // A terminal or panel emergency stop is latched by the next edge.
  chk_estop_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    estop_alarm_i || estop_req |=> estop_alarm_q)
    else $error("emergency stop not latched");

  // An emergency-stop fault alone keeps the alarm lamp steadily lit.
  chk_estop_fault_lamp: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    drive_ready_i && !fault_q && !estop_alarm_q && estop_fault_q |=> alarm_lamp_o)
    else $error("alarm dark on emergency-stop fault");

  // A run request under external baseblock shows the running-alarm pattern.
  chk_bb_run_alarm: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    drive_ready_i && !fault_q && !estop_alarm_q && !estop_fault_q && run_cmd_i
    && ext_baseblock_i |=> run_lamp_o) else $error("run lamp dark under baseblock run");

  // Deceleration never lights the alarm lamp.
  chk_decel_alarm_dark: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cond == COND_DECEL |=> !alarm_lamp_o) else $error("alarm lit while decelerating");

  // A latched fault keeps the run lamp dark.
  chk_fault_run_dark: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    drive_ready_i && fault_q |=> !run_lamp_o) else $error("run lamp lit on fault");

  // Two lamps flashing together stay in phase, as they share one toggle.
  chk_flash_in_phase: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    run_pat == LAMP_FLASH && alm_pat == LAMP_FLASH |=> run_lamp_o == alarm_lamp_o)
    else $error("flashing lamps out of phase");

endmodule

//--- test/panel_keys_model.sv
// Model of the operator keypad: turns one-cycle press requests into key levels.
// Assumes requests are raised by the bench just after a rising edge of clk_i.
module panel_keys_model (
  // Clock.
  input  wire logic clk_i,
  // Press requests from the bench.
  input  wire logic stop_req_i,
  input  wire logic disp_req_i,
  // Key levels toward the block.
  output logic      stop_key_o,
  output logic      display_select_key_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // A key stays down one cycle and is always released for one cycle after,
  // so of two requests in a row the second is dropped and gives no rising edge.
  always_ff @(posedge clk_i) begin
    stop_key_o           <= stop_req_i && !stop_key_o;
    display_select_key_o <= disp_req_i && !display_select_key_o;
  end
endmodule

//--- test/testbench.sv
// Self-checking bench for the drive status indicator logic.
// Assumes a short flash half period of 4 cycles and the keypad model beside it.
module testbench;
  import status_ind_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus and observed signals.
  logic clk_i = 1'b0, rst_b_i = 1'b0;
  logic rdy = 1'b0, flt = 1'b0, alm = 1'b0, ebb = 1'b0, act = 1'b0, dec = 1'b0;
  logic term = 1'b0, run = 1'b0, frst = 1'b0, ea = 1'b0, ef = 1'b0, pm = 1'b0;
  logic stop_req = 1'b0, disp_req = 1'b0, stop_key, disp_key;
  logic [3:0] acc = 4'h0;
  logic rk, rl, al, pgm, ren, fl;
  logic [FUNC_W-1:0] fs;
  int fail_count = 0, n_checks = 0;

  // The clock toggles every 10 ns, half of its 20 ns period.
  always #10 clk_i = ~clk_i;

  panel_keys_model i_panel_keys_model (.clk_i(clk_i), .stop_req_i(stop_req),
    .disp_req_i(disp_req), .stop_key_o(stop_key), .display_select_key_o(disp_key));

  drive_status_indicator_logic #(.FLASH_HALF(4)) i_drive_status_indicator_logic (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .drive_ready_i(rdy), .fault_event_i(flt),
    .alarm_i(alm), .ext_baseblock_i(ebb), .output_active_i(act), .decel_i(dec),
    .terminal_ctrl_i(term), .run_cmd_i(run), .fault_reset_i(frst),
    .estop_alarm_i(ea), .estop_fault_i(ef), .stop_key_i(stop_key),
    .display_select_key_i(disp_key), .param_mode_i(pm), .param_access_level_i(acc),
    .run_key_lamp_o(rk), .run_lamp_o(rl), .alarm_lamp_o(al), .func_sel_o(fs),
    .program_mode_o(pgm), .run_enable_o(ren), .fault_latched_o(fl));

  // Waits a number of rising edges.
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Lets the lamps settle for two edges, so the old condition is not seen,
  // then watches them over 12 cycles and returns on a rising edge.
  task automatic watch(output logic run_seen, output logic alm_seen);
    run_seen = 1'b0;
    alm_seen = 1'b0;
    step(2);
    repeat (12) begin
      @(negedge clk_i);
      run_seen |= rl;
      alm_seen |= al;
      chk("run key lamp", {3'h0, rl}, {3'h0, rk});
    end
    @(posedge clk_i);
  endtask

  // Latches a fault, refuses a clear under run, then clears two ways.
  task automatic fault_scn();
    flt <= 1'b1; step(1); flt <= 1'b0; step(4);
    chk("fault latch", 4'h1, {3'h0, fl});
    chk("alarm lamp", 4'h1, {3'h0, al});
    chk("run lamp", 4'h0, {3'h0, rl});
    run <= 1'b1; frst <= 1'b1; step(2); frst <= 1'b0; step(3);
    chk("fault kept", 4'h1, {3'h0, fl});
    run <= 1'b0; step(2); frst <= 1'b1; step(1); frst <= 1'b0; step(4);
    chk("fault reset", 4'h0, {3'h0, fl});
    flt <= 1'b1; step(1); flt <= 1'b0; step(4);
    stop_req <= 1'b1; step(1); stop_req <= 1'b0; step(5);
    chk("stop clear", 4'h0, {3'h0, fl});
    chk("alarm off", 4'h0, {3'h0, al});
  endtask

  // Eight presses walk the function index round to its start.
  task automatic select_scn();
    for (int k = 1; k <= NUM_FUNC; k++) begin
      disp_req <= 1'b1; step(1); disp_req <= 1'b0; step(4);
      chk("function index", 4'(k % NUM_FUNC), {1'b0, fs});
    end
  endtask

  // Ranked conditions: dark when not ready, alarm, e-stop fault, run, decel.
  task automatic rank_scn();
    logic r, a;
    rdy <= 1'b0; alm <= 1'b1; watch(r, a);
    chk("not ready lamps", 4'h0, {2'h0, r, a});
    rdy <= 1'b1; watch(r, a);
    chk("alarm stopped", 4'h1, {3'h0, a});
    alm <= 1'b0; ef <= 1'b1; watch(r, a);
    chk("estop fault lamps", 4'h1, {2'h0, r, a});
    ef <= 1'b0; frst <= 1'b1; step(2); frst <= 1'b0;
    run <= 1'b1; act <= 1'b1; watch(r, a);
    chk("running lamps", 4'h2, {2'h0, r, a});
    run <= 1'b0; act <= 1'b0; dec <= 1'b1; watch(r, a);
    chk("decel alarm", 4'h0, {3'h0, a});
    dec <= 1'b0;
  endtask

  // Emergency stop from the panel and the terminals, then run under baseblock.
  task automatic estop_scn();
    logic r, a;
    term <= 1'b1; stop_req <= 1'b1; step(1); stop_req <= 1'b0; watch(r, a);
    chk("panel estop lamps", 4'h3, {2'h0, r, a});
    term <= 1'b0; run <= 1'b1; watch(r, a);
    chk("estop released", 4'h0, {3'h0, a});
    run <= 1'b0; ea <= 1'b1; step(1); ea <= 1'b0; watch(r, a);
    chk("terminal estop lamps", 4'h3, {2'h0, r, a});
    run <= 1'b1; ebb <= 1'b1; watch(r, a);
    chk("baseblock run lamps", 4'h3, {2'h0, r, a});
    run <= 1'b0; ebb <= 1'b0; step(2);
  endtask

  // A reset with the drive stopped drops a latched fault and program mode.
  task automatic reset_scn();
    flt <= 1'b1; step(1); flt <= 1'b0; step(3);
    chk("fault before reset", 4'h1, {3'h0, fl});
    rst_b_i <= 1'b0; step(2);
    chk("outputs in reset", 4'h0, {fl, al, pgm, ren});
    rst_b_i <= 1'b1; step(3);
    chk("fault after reset", 4'h0, {3'h0, fl});
    chk("mode after reset", 4'h0, {3'h0, pgm});
  endtask

  // Stop after a parameter mode entered while running forces program mode.
  task automatic prog_scn();
    run <= 1'b1; act <= 1'b1; step(3); pm <= 1'b1; step(3);
    run <= 1'b0; act <= 1'b0; step(4);
    chk("program mode", 4'h1, {3'h0, pgm});
    chk("run refused", 4'h0, {3'h0, ren});
    acc <= ACCESS_RUN_IN_PRGM; step(4);
    chk("run allowed", 4'h1, {3'h0, ren});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence: reset for 3 cycles, then each scenario in turn.
  initial begin
    step(3);
    chk("lamps in reset", 4'h0, {1'b0, rl, al, fl});
    rst_b_i <= 1'b1; rdy <= 1'b1; step(3);
    fault_scn();
    select_scn();
    rank_scn();
    estop_scn();
    prog_scn();
    reset_scn();
    results();
  end

  // Watchdog: the scenarios need well under 1000 cycles.
  initial begin
    step(5000);
    fail_count++;
    results();
  end
endmodule
